// [router_map.svh]
// Purpose: constants for the shared function message router
// Assumes: descriptor layout chosen for this block
// Notes: included by router files
// Overview of operation
// RULE1 - Each function has unique 4-bit identifier
// RULE2 - Routing identifier taken from 32-bit descriptor
// RULE3 - Sub-operation sits in 16-bit control field
// RULE4 - Sub-operation passed through, never decoded
// RULE5 - Results return to originating execution core
// RULE6 - Gateway may target core named in message
// RULE7 - Gateway links threads through a key
// RULE8 - Null function accepts, never responds
// RULE9 - Dispatcher arbitrates starts, allocates thread registers
// RULE10 - Thread launcher forwards spawn requests to dispatcher
// RULE11 - Hold until accepted, keep issue order
`ifndef ROUTER_MAP_SVH
`define ROUTER_MAP_SVH
`define FID_LSB        0
`define FID_W          4
`define SUBOP_LSB      16
`define SUBOP_W        16
`define FID_NULL       4'h0
`define FID_GATEWAY    4'h3
`define FID_LAUNCHER   4'h7
`define CORE_LSB       0
`define KEY_LSB        8
`define THREAD_LSB     24
`define FIFO_DEPTH     16
`endif

// [router_pkg.sv]
// Purpose: types for the router
// Assumes: none
// Notes: none
package router_pkg;
    typedef logic [3:0]  fid_t;
    typedef logic [31:0] word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_RESP = 3'b100
    } state_e;
endpackage : router_pkg

// [msg_if.sv]
// Purpose: stream carrier between router modules
// Assumes: one clock
// Notes: valid/ready
`timescale 1ns/1ns
interface msg_if #(parameter int W = 64);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : msg_if

// [msg_fifo.sv]
// Purpose: message buffer in the request path
// Assumes: synchronous inputs
// Notes: read data taken straight from memory, not registered
`timescale 1ns/1ns
module msg_fifo #(
    parameter int W     = 64,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    msg_if.snk        wr,
    msg_if.src        rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;
    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH)) || rd.ready;
    assign push = wr.valid && wr.ready;
    assign pop  = rd.valid && rd.ready;
    // Pointers and count advance on push and pop; no output register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= wr.data;
        end
    end
    assign rd.valid = (cnt_reg != '0);
    assign rd.data  = mem[rp_reg];
    // Order kept: strict first in, first out  (see RULE11)
endmodule : msg_fifo

// [msg_router.sv]
// Purpose: routes core messages to shared functions and returns replies
// Assumes: one message is handled at a time past the buffer
// Notes: payload word 0 carries core, key and thread fields
`timescale 1ns/1ns
`include "router_map.svh"
module msg_router #(
    parameter int NFUNC = 16,
    parameter int NCORE = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire logic [31:0]       req_desc,
    input  wire logic [31:0]       req_payload,
    input  wire logic [7:0]        req_src_core,
    output logic                   req_ready,
    output logic [NFUNC-1:0]       fn_valid,
    output logic [15:0]            fn_subop,
    output logic [31:0]            fn_payload,
    output logic [7:0]             fn_src_core,
    input  wire logic [NFUNC-1:0]  fn_ready,
    input  wire logic              fn_resp_valid,
    input  wire logic [31:0]       fn_resp_data,
    output logic                   fn_resp_ready,
    output logic                   resp_valid,
    output logic [7:0]             resp_core,
    output logic [31:0]            resp_data,
    input  wire logic              resp_ready,
    output logic                   spawn_valid,
    output logic [31:0]            spawn_data,
    input  wire logic              spawn_ready,
    output logic [7:0]             gw_key,
    output logic [7:0]             gw_thread
);
    msg_if #(.W(72)) in_q ();
    msg_if #(.W(72)) out_q ();
    router_pkg::state_e state_reg;
    logic [31:0] desc_reg;
    logic [31:0] pay_reg;
    logic [7:0]  src_reg;
    logic        cur_ack;
    logic        need_resp;
    router_pkg::fid_t fid;
    assign in_q.valid = req_valid;
    assign in_q.data  = {req_src_core, req_desc, req_payload};
    assign req_ready  = in_q.ready;
    msg_fifo #(.W(72), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk (clk),
        .rst (rst),
        .wr  (in_q),
        .rd  (out_q)
    );
    function automatic router_pkg::fid_t get_fid(input logic [31:0] d);
        get_fid = d[`FID_LSB +: `FID_W];
    endfunction : get_fid
    assign fid = get_fid(desc_reg); // see RULE2
    // Only null and launcher produce no reply on this path
    assign need_resp = (fid != `FID_NULL) && (fid != `FID_LAUNCHER); // see RULE8
    assign out_q.ready = (state_reg == router_pkg::ST_IDLE);
    assign cur_ack = (fid == `FID_LAUNCHER) ? (spawn_valid && spawn_ready)
                   : (fn_valid[fid] && fn_ready[fid]);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= router_pkg::ST_IDLE;
            desc_reg <= '0;
            pay_reg <= '0;
            src_reg <= '0;
        end else begin
            case (state_reg)
                router_pkg::ST_IDLE: begin
                    if (out_q.valid) begin
                        {src_reg, desc_reg, pay_reg} <= out_q.data;
                        state_reg <= router_pkg::ST_SEND;
                    end
                end
                router_pkg::ST_SEND: begin
                    // Held until taken  (see RULE11)
                    if (cur_ack) begin
                        state_reg <= need_resp ? router_pkg::ST_RESP : router_pkg::ST_IDLE;
                    end
                end
                router_pkg::ST_RESP: begin
                    if (fn_resp_valid && fn_resp_ready) begin
                        state_reg <= router_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= router_pkg::ST_IDLE;
            endcase
        end
    end
    // One-hot delivery to matching function  (see RULE1)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fn_valid <= '0;
            fn_subop <= '0;
            fn_payload <= '0;
            fn_src_core <= '0;
        end else if (state_reg == router_pkg::ST_IDLE && out_q.valid) begin
            fn_valid <= '0;
            if (get_fid(out_q.data[63:32]) != `FID_LAUNCHER) begin
                fn_valid[get_fid(out_q.data[63:32])] <= 1'b1;
            end
            fn_subop <= out_q.data[32+`SUBOP_LSB +: `SUBOP_W]; // see RULE3 see RULE4
            fn_payload <= out_q.data[31:0];
            fn_src_core <= out_q.data[71:64];
        end else if (state_reg == router_pkg::ST_SEND && cur_ack) begin
            fn_valid <= '0;
        end
    end
    // Launcher requests go to dispatcher, which assigns core thread  (see RULE10 see RULE9)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spawn_valid <= 1'b0;
            spawn_data <= '0;
        end else if (state_reg == router_pkg::ST_IDLE && out_q.valid
                     && get_fid(out_q.data[63:32]) == `FID_LAUNCHER) begin
            spawn_valid <= 1'b1;
            spawn_data <= out_q.data[31:0];
        end else if (spawn_ready) begin
            spawn_valid <= 1'b0;
        end
    end
    // Gateway key and receiver thread exposed to the gateway  (see RULE7)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gw_key <= '0;
            gw_thread <= '0;
        end else if (state_reg == router_pkg::ST_SEND && fid == `FID_GATEWAY) begin
            gw_key <= pay_reg[`KEY_LSB +: 8];
            gw_thread <= pay_reg[`THREAD_LSB +: 8];
        end
    end
    // Reply register; single slot so no reply is dropped
    assign fn_resp_ready = (state_reg == router_pkg::ST_RESP) && (!resp_valid || resp_ready);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_core <= '0;
            resp_data <= '0;
        end else if (fn_resp_valid && fn_resp_ready) begin
            resp_valid <= 1'b1;
            resp_data <= fn_resp_data;
            resp_core <= (fid == `FID_GATEWAY) ? pay_reg[`CORE_LSB +: 8] : src_reg; // see RULE6 see RULE5
        end else if (resp_ready) begin
            resp_valid <= 1'b0;
        end
    end
    hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == router_pkg::ST_SEND && !cur_ack) |=> state_reg == router_pkg::ST_SEND)
        else $error("message dropped before acceptance"); // see RULE11
    onehot_a: assert property (@(posedge clk) disable iff (rst) $onehot0(fn_valid))
        else $error("message sent to several functions"); // see RULE1
    match_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == router_pkg::ST_SEND && fn_valid != '0) |-> fn_valid[fid])
        else $error("wrong function selected"); // see RULE2
    subop_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == router_pkg::ST_SEND) |-> fn_subop == desc_reg[`SUBOP_LSB +: `SUBOP_W])
        else $error("sub-operation altered"); // see RULE4
    null_resp_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == router_pkg::ST_SEND && fid == `FID_NULL && cur_ack)
        |=> state_reg == router_pkg::ST_IDLE)
        else $error("null function waited for reply"); // see RULE8
    ret_core_a: assert property (@(posedge clk) disable iff (rst)
        (fn_resp_valid && fn_resp_ready && fid != `FID_GATEWAY) |=> resp_core == $past(src_reg))
        else $error("reply not returned to sender"); // see RULE5
    gw_core_a: assert property (@(posedge clk) disable iff (rst)
        (fn_resp_valid && fn_resp_ready && fid == `FID_GATEWAY)
        |=> resp_core == $past(pay_reg[7:0]))
        else $error("gateway reply misrouted"); // see RULE6
    spawn_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == router_pkg::ST_SEND && fid == `FID_LAUNCHER) |-> spawn_valid && fn_valid == '0)
        else $error("launcher request not forwarded"); // see RULE10
endmodule : msg_router

// [fn_model.sv]
// Purpose: shared function partner model
// Assumes: one request in flight at a time
// Notes: reply is sub-op over low payload half
`timescale 1ns/1ns
module fn_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall,
    input  wire logic [15:0] fn_valid,
    input  wire logic [15:0] fn_subop,
    input  wire logic [31:0] fn_payload,
    output logic      [15:0] fn_ready,
    output logic             fn_resp_valid,
    output logic      [31:0] fn_resp_data,
    input  wire logic        fn_resp_ready
);
    logic [31:0] data_reg;
    assign fn_ready = stall ? 16'h0 : fn_valid;
    // Idle bus shows inverse so stale data is never taken for a reply
    assign fn_resp_data = fn_resp_valid ? data_reg : ~data_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fn_resp_valid <= 1'b0;
            data_reg      <= 32'h0;
        end else if (|(fn_valid & fn_ready) && !fn_valid[0]) begin
            fn_resp_valid <= 1'b1;
            data_reg      <= {fn_subop, fn_payload[15:0]};
        end else if (fn_resp_ready) begin
            fn_resp_valid <= 1'b0;
        end
    end
endmodule : fn_model

// [shared_function_message_router_bench.sv]
// Purpose: self-checking bench for the message router
// Assumes: partner replies with sub-op and low payload
// Notes: spawn data taken as the request payload
`timescale 1ns/1ns
module shared_function_message_router_bench;
    logic        clk = 0, rst = 1, stall = 0;
    logic        req_valid = 0, resp_ready = 0, spawn_ready = 1;
    logic [31:0] req_desc = 0, req_payload = 0;
    logic [7:0]  req_src_core = 0;
    logic [15:0] fn_valid, fn_ready, fn_subop, hs_fv, hs_sub;
    logic [31:0] fn_payload, fn_resp_data, resp_data, spawn_data, sp_data, d;
    logic [7:0]  fn_src_core, resp_core, gw_key, gw_thread, hs_src, c;
    logic        fn_resp_valid, fn_resp_ready, resp_valid, spawn_valid, req_ready;
    int          err_count = 0, tests_run = 0, cyc = 0, resp_seen = 0, sp_seen = 0;
    bit          ok;
    always #4 clk = ~clk;
    msg_router u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_desc(req_desc),
        .req_payload(req_payload), .req_src_core(req_src_core), .req_ready(req_ready),
        .fn_valid(fn_valid), .fn_subop(fn_subop), .fn_payload(fn_payload),
        .fn_src_core(fn_src_core), .fn_ready(fn_ready), .fn_resp_valid(fn_resp_valid),
        .fn_resp_data(fn_resp_data), .fn_resp_ready(fn_resp_ready),
        .resp_valid(resp_valid), .resp_core(resp_core), .resp_data(resp_data),
        .resp_ready(resp_ready), .spawn_valid(spawn_valid), .spawn_data(spawn_data),
        .spawn_ready(spawn_ready), .gw_key(gw_key), .gw_thread(gw_thread));
    fn_model u_fn (.clk(clk), .rst(rst), .stall(stall), .fn_valid(fn_valid),
        .fn_subop(fn_subop), .fn_payload(fn_payload), .fn_ready(fn_ready),
        .fn_resp_valid(fn_resp_valid), .fn_resp_data(fn_resp_data),
        .fn_resp_ready(fn_resp_ready));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (|(fn_valid & fn_ready)) begin
            hs_fv <= fn_valid;
            hs_sub <= fn_subop;
            hs_src <= fn_src_core;
        end
        if (resp_valid) resp_seen <= resp_seen + 1;
        if (spawn_valid && spawn_ready) begin
            sp_seen <= sp_seen + 1;
            sp_data <= spawn_data;
        end
        // Whole run needs about 200 cycles
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Leaves valid high; caller lowers it so back-to-back sends stay clean
    task automatic send(input logic [31:0] dd, input logic [31:0] p, input int tries);
        req_desc = dd;
        req_payload = p;
        req_valid = 1;
        ok = 0;
        repeat (tries) begin
            @(negedge clk);
            if (req_ready === 1'b1) begin
                ok = 1;
                break;
            end
        end
        @(posedge clk);
        #1;
    endtask : send
    task automatic get_resp();
        resp_ready = 1;
        c = 'x;
        d = 'x;
        repeat (60) begin
            @(negedge clk);
            if (resp_valid === 1'b1) begin
                c = resp_core;
                d = resp_data;
                break;
            end
        end
        @(posedge clk);
        #1;
    endtask : get_resp
    task automatic t_route();
        for (int f = 1; f < 16; f++) if (f != 3 && f != 7) begin
            req_src_core = 8'(f + 8'h40);
            send({4'(f), 12'ha5c, 12'h0, 4'(f)}, 32'h1234_0000 + f, 20);
            req_valid = 0;
            get_resp();
            resp_ready = 0;
            chk(hs_fv, 16'h1 << f);
            chk({hs_sub, hs_src}, {4'(f), 12'ha5c, 8'(f + 8'h40)});
            chk({c, d}, {8'(f + 8'h40), 4'(f), 12'ha5c, 16'(f)});
        end
    endtask : t_route
    task automatic t_gateway();
        req_src_core = 8'h11;
        send({16'h0042, 12'h0, 4'h3}, 32'h5a00_3c06, 20);
        req_valid = 0;
        get_resp();
        resp_ready = 0;
        chk({c, d}, {8'h06, 16'h0042, 16'h3c06});
        chk({gw_key, gw_thread, hs_fv}, {8'h3c, 8'h5a, 16'h0008});
    endtask : t_gateway
    task automatic t_null_spawn();
        int r;
        int s;
        r = resp_seen;
        s = sp_seen;
        send({16'h0001, 12'h0, 4'h0}, 32'h0000_00ee, 20);
        req_valid = 0;
        repeat (10) @(posedge clk);
        #1;
        chk({hs_fv, 32'(resp_seen)}, {16'h0001, 32'(r)});
        // Dispatcher busy: request must be held, not lost
        spawn_ready = 0;
        send({16'h0009, 12'h0, 4'h7}, 32'hc0de_0007, 20);
        req_valid = 0;
        repeat (10) @(posedge clk);
        #1;
        chk({spawn_valid, 32'(sp_seen)}, {1'b1, 32'(s)});
        spawn_ready = 1;
        repeat (10) @(posedge clk);
        #1;
        // Launcher must bypass its function port
        chk({hs_fv, 32'(sp_seen)}, {16'h0001, 32'(s + 1)});
        chk(sp_data, 32'hc0de_0007);
    endtask : t_null_spawn
    task automatic t_fill();
        int n;
        n = 0;
        stall = 1;
        for (int i = 0; i < 24; i++) begin
            send({16'(i), 12'h0, 4'h1}, 32'(i), 1);
            if (!ok) break;
            n++;
        end
        req_valid = 0;
        chk({ok, n >= 16}, {1'b0, 1'b1});
        stall = 0;
        for (int i = 0; i < n; i++) begin
            get_resp();
            chk(d, {16'(i), 16'(i)});
        end
        resp_ready = 0;
    endtask : t_fill
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        t_route();
        t_gateway();
        t_null_spawn();
        t_fill();
        results();
    end
endmodule : shared_function_message_router_bench
